// ===== towsel_map.vh
// Purpose: Register offsets, field positions and reset values of the trigger output unit.
// Assumes: Plain register port, word addresses counted by index.
// Notes: Included by the trigger output design files.
`ifndef TOWSEL_MAP_VH
`define TOWSEL_MAP_VH
`define TOWSEL_ADDR_W 3
`define TOWSEL_REG_CTL1 3'h0
`define TOWSEL_REG_WIDTH 3'h1
`define TOWSEL_REG_PAT 3'h2
`define TOWSEL_REG_PULSE 3'h3
`define TOWSEL_REG_TARGET 3'h4
`define TOWSEL_REG_ARM 3'h5
`define TOWSEL_REG_STAT 3'h6
`define TOWSEL_CTL1_MASK 32'hc071ffff
`define TOWSEL_CTL1_RST 32'h00000000
`define TOWSEL_F_CASC 31
`define TOWSEL_F_TAIL 30
`define TOWSEL_F_WAVE_HI 22
`define TOWSEL_F_WAVE_LO 20
`define TOWSEL_F_PIN 16
`define TOWSEL_F_ITER_HI 15
`define TOWSEL_W_FALL 3'h0
`define TOWSEL_W_RISE 3'h1
`define TOWSEL_W_NPULSE 3'h2
`define TOWSEL_W_PPULSE 3'h3
`define TOWSEL_W_NPER 3'h4
`define TOWSEL_W_PPER 3'h5
`define TOWSEL_W_PATT 3'h6
`define TOWSEL_W_RSVD 3'h7
`endif

// ===== towsel_gen.v
// Purpose: Waveform engine of one trigger output unit.
// Assumes: Widths are counted in clock cycles; start is a one-cycle pulse.
// Notes: Output idles at the level each waveform code calls for.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "towsel_map.vh"
module towsel_gen #(
  parameter CW = 32
) (
  input wire clock_i,
  input wire reset_n_i,
  // Control.
  input wire start_i,
  input wire stop_i,
  input wire [2:0] wave_i,
  input wire [CW-1:0] pulse_w_i,
  input wire [CW-1:0] cycle_w_i,
  input wire [15:0] count_i,
  input wire [15:0] pattern_i,
  input wire casc_i,
  input wire tail_i,
  input wire [15:0] iter_i,
  // Result.
  output reg wave_o,
  output reg busy_o
);
  reg [CW-1:0] tick_q;
  reg [15:0] done_q;
  reg [3:0] bit_q;
  reg [15:0] pass_q;
  reg active_q;
  // Once a waveform has fired, its final level stands until a stop, or the reserved code 111, returns it to idle.
  reg fired_q;

  function idle_level;
    input [2:0] w;
    begin
      idle_level = (w == `TOWSEL_W_FALL) || (w == `TOWSEL_W_NPULSE) || (w == `TOWSEL_W_NPER);
    end
  endfunction

  wire idle = idle_level(wave_i);
  wire [CW-1:0] pw = (pulse_w_i == {CW{1'b0}}) ? {{(CW-1){1'b0}}, 1'b1} : pulse_w_i;
  wire [CW-1:0] cw = (cycle_w_i <= pw) ? pw + {{(CW-1){1'b0}}, 1'b1} : cycle_w_i;
  wire [CW-1:0] bw = (cycle_w_i == {CW{1'b0}}) ? {{(CW-1){1'b0}}, 1'b1} : cycle_w_i;

  always @* begin
    busy_o = active_q;
  end

  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      wave_o <= 1'b0;
      active_q <= 1'b0;
      tick_q <= {CW{1'b0}};
      done_q <= 16'h0000;
      bit_q <= 4'hf;
      pass_q <= 16'h0000;
      fired_q <= 1'b0;
    end else if (stop_i) begin
      active_q <= 1'b0;
      fired_q <= 1'b0;
      wave_o <= idle;
    end else if (start_i && !active_q) begin
      fired_q <= 1'b1;
      tick_q <= {CW{1'b0}};
      done_q <= 16'h0000;
      bit_q <= 4'hf;
      pass_q <= 16'h0000;
      case (wave_i)
        `TOWSEL_W_FALL, `TOWSEL_W_RISE: begin
          wave_o <= ~idle;
        end
        `TOWSEL_W_NPULSE, `TOWSEL_W_PPULSE, `TOWSEL_W_NPER, `TOWSEL_W_PPER: begin
          wave_o <= ~idle;
          active_q <= 1'b1;
        end
        `TOWSEL_W_PATT: begin
          wave_o <= pattern_i[15];
          active_q <= 1'b1;
        end
        default: begin
          wave_o <= idle;
        end
      endcase
    end else if (!active_q) begin
      if (!fired_q || wave_i == `TOWSEL_W_RSVD) begin
        wave_o <= idle;
      end
    end else begin
      tick_q <= tick_q + {{(CW-1){1'b0}}, 1'b1};
      case (wave_i)
        `TOWSEL_W_NPULSE, `TOWSEL_W_PPULSE: begin
          if (tick_q + {{(CW-1){1'b0}}, 1'b1} >= pw) begin
            wave_o <= idle;
            active_q <= 1'b0;
          end
        end
        `TOWSEL_W_NPER, `TOWSEL_W_PPER: begin
          if (tick_q + {{(CW-1){1'b0}}, 1'b1} == pw) begin
            wave_o <= idle;
          end
          if (tick_q + {{(CW-1){1'b0}}, 1'b1} >= cw) begin
            tick_q <= {CW{1'b0}};
            if (count_i != 16'h0000 && done_q + 16'h0001 >= count_i) begin
              active_q <= 1'b0;
              wave_o <= idle;
            end else begin
              done_q <= done_q + 16'h0001;
              wave_o <= ~idle;
            end
          end
        end
        `TOWSEL_W_PATT: begin
          if (tick_q + {{(CW-1){1'b0}}, 1'b1} >= bw) begin
            tick_q <= {CW{1'b0}};
            done_q <= done_q + 16'h0001;
            bit_q <= bit_q - 4'h1;
            if (bit_q == 4'h0) begin
              pass_q <= pass_q + 16'h0001;
            end
            if (casc_i && tail_i && bit_q == 4'h0 && pass_q >= iter_i) begin
              active_q <= 1'b0;
              wave_o <= 1'b0;
            end else if (!(casc_i && tail_i) && !casc_i && count_i != 16'h0000 &&
                         done_q + 16'h0001 >= count_i) begin
              active_q <= 1'b0;
              wave_o <= 1'b0;
            end else begin
              wave_o <= pattern_i[bit_q - 4'h1];
            end
          end
        end
        default: begin
          active_q <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== towsel_top.v
// Function
// - Start waveform when armed and time reached.
// - Codes 000/001 make falling/rising edge.
// - Codes 010/011 make one pulse.
// - Codes 100/101 periodic; zero count endless.
// - Code 110 shifts pattern MSB first, looped.
// - Pattern stops after bit total; zero endless. Cascade (bit 31) ignores bit total.
// - Bit 16 picks first or second pin.
// - Units on one pin are ORed.
// - Tail unit repeats pattern count plus one.
// - No tail: iteration count ignored, endless.
// - Bit 30 marks cascade tail unit.
// Purpose: Register-driven trigger output unit with pin routing.
// Assumes: System time arrives on the same clock; other units arrive as ORed levels.
// Notes: Register reads answer one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
`include "towsel_map.vh"
module towsel_top #(
  parameter CW = 32,
  parameter TW = 64
) (
  input wire clock_i,
  input wire reset_n_i,
  // Register port.
  input wire [`TOWSEL_ADDR_W-1:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  // Time and other units.
  input wire [TW-1:0] sys_time_i,
  input wire other_pin1_i,
  input wire other_pin2_i,
  // Pins.
  output reg gp_pin1_o,
  output reg gp_pin2_o
);
  reg [31:0] ctl1_q;
  reg [CW-1:0] width_q;
  reg [31:0] pat_q;
  reg [CW-1:0] pulse_q;
  reg [TW-1:0] target_q;
  reg trigger_arm_q;
  reg start_q;
  wire wave;
  wire busy;
  wire stop = wr_i && addr_i == `TOWSEL_REG_ARM && !wdata_i[0];

  // Arming is cleared when the start pulse is raised, one cycle before the generator acts on it.
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      ctl1_q <= `TOWSEL_CTL1_RST;
      width_q <= {CW{1'b0}};
      pat_q <= 32'h00000000;
      pulse_q <= {CW{1'b0}};
      target_q <= {TW{1'b0}};
      trigger_arm_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (trigger_arm_q && sys_time_i >= target_q && !start_q) begin
        start_q <= 1'b1;
        trigger_arm_q <= 1'b0;
      end
      if (wr_i) begin
        case (addr_i)
          `TOWSEL_REG_CTL1: ctl1_q <= wdata_i & `TOWSEL_CTL1_MASK;
          `TOWSEL_REG_WIDTH: width_q <= wdata_i[CW-1:0];
          `TOWSEL_REG_PAT: pat_q <= wdata_i;
          `TOWSEL_REG_PULSE: pulse_q <= wdata_i[CW-1:0];
          `TOWSEL_REG_TARGET: target_q <= {target_q[TW-33:0], wdata_i};
          `TOWSEL_REG_ARM: trigger_arm_q <= wdata_i[0];
          default: begin
          end
        endcase
      end
    end
  end

  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      case (addr_i)
        `TOWSEL_REG_CTL1: rdata_o <= ctl1_q;
        `TOWSEL_REG_WIDTH: rdata_o <= width_q;
        `TOWSEL_REG_PAT: rdata_o <= pat_q;
        `TOWSEL_REG_PULSE: rdata_o <= pulse_q;
        `TOWSEL_REG_TARGET: rdata_o <= target_q[31:0];
        `TOWSEL_REG_ARM: rdata_o <= {31'h00000000, trigger_arm_q};
        `TOWSEL_REG_STAT: rdata_o <= {30'h00000000, wave, busy};
        default: rdata_o <= 32'h00000000;
      endcase
    end else begin
      rdata_o <= 32'h00000000;
    end
  end

  towsel_gen #(.CW(CW)) u_gen (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .start_i(start_q),
    .stop_i(stop),
    .wave_i(ctl1_q[`TOWSEL_F_WAVE_HI:`TOWSEL_F_WAVE_LO]),
    .pulse_w_i(pulse_q),
    .cycle_w_i(width_q),
    .count_i(pat_q[31:16]),
    .pattern_i(pat_q[15:0]),
    .casc_i(ctl1_q[`TOWSEL_F_CASC]),
    .tail_i(ctl1_q[`TOWSEL_F_TAIL]),
    .iter_i(ctl1_q[`TOWSEL_F_ITER_HI:0]),
    .wave_o(wave),
    .busy_o(busy)
  );

  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      gp_pin1_o <= 1'b0;
      gp_pin2_o <= 1'b0;
    end else begin
      gp_pin1_o <= other_pin1_i | (wave & !ctl1_q[`TOWSEL_F_PIN]);
      gp_pin2_o <= other_pin2_i | (wave & ctl1_q[`TOWSEL_F_PIN]);
    end
  end
endmodule
`default_nettype wire

// ===== towsel_monitor.sv
// Purpose: Port checks of the trigger output unit.
// Assumes: One clock; reset active low.
// Notes: Bound to towsel_top after the module.
`timescale 1ns/1ps
`default_nettype none
module towsel_monitor (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Register port.
  input wire logic [2:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // Pins.
  input wire logic other_pin1_i,
  input wire logic other_pin2_i,
  input wire logic gp_pin1_o,
  input wire logic gp_pin2_o
);
  logic wr0_q;
  logic sel_q;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      wr0_q <= 1'b0;
      sel_q <= 1'b0;
    end else if (wr_i && addr_i == 3'h0) begin
      wr0_q <= 1'b1;
      sel_q <= wdata_i[16];
    end
  end
  sequence s_wr0;
    wr_i && addr_i == 3'h0;
  endsequence
  sequence s_rd0;
    rd_i && !wr_i && addr_i == 3'h0;
  endsequence
  AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data outside read slot");
  AST_UNMAP: assert property (rd_i && addr_i == 3'h7 |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_CTL_RSVD: assert property (s_rd0 |=> (rdata_o & ~32'hc071ffff) == 32'h0)
    else $error("reserved control bits set");
  AST_CTL_RST: assert property (s_rd0 and !wr0_q |=> rdata_o == 32'h0)
    else $error("control reset value wrong");
  AST_CTL_BACK: assert property (s_wr0 ##1 s_rd0 |=>
    rdata_o == ($past(wdata_i, 2) & 32'hc071ffff))
    else $error("control readback wrong");
  AST_OR_1: assert property (other_pin1_i |=> gp_pin1_o)
    else $error("pin one lost other unit");
  AST_SEL_1: assert property ((sel_q && !other_pin1_i)[*4] |-> !gp_pin1_o)
    else $error("pin one driven while routed away");
  AST_SEL_2: assert property ((!sel_q && !other_pin2_i)[*4] |-> !gp_pin2_o)
    else $error("pin two driven while routed away");
endmodule
bind towsel_top towsel_monitor u_mon (.clock_i(clock_i), .reset_n_i(reset_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .other_pin1_i(other_pin1_i), .other_pin2_i(other_pin2_i), .gp_pin1_o(gp_pin1_o),
  .gp_pin2_o(gp_pin2_o));
`default_nettype wire

// ===== towsel_ext_model.sv
// Purpose: Equipment watching output pin one.
// Assumes: Counts restart while clr_i is high.
// Notes: Also plays another unit on pin one.
`timescale 1ns/1ps
`default_nettype none
module towsel_ext_model (
  input wire logic clock_i,
  input wire logic clr_i,
  input wire logic pin1_i,
  input wire logic drive1_i,
  output wire logic unit1_o,
  output var logic [15:0] hi1_o,
  output var logic [15:0] rise1_o
);
  logic last_q;
  assign unit1_o = drive1_i;
  always @(posedge clock_i) begin
    last_q <= pin1_i;
    hi1_o <= clr_i ? 16'h0 : hi1_o + 16'(pin1_i);
    rise1_o <= clr_i ? 16'h0 : rise1_o + 16'(pin1_i & ~last_q);
  end
endmodule
`default_nettype wire

// ===== testbench.sv
// Purpose: Self-checking bench for towsel_top.
// Assumes: System time counts one per clock.
// Notes: Each waveform test arms the unit and counts pin one levels.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, w) chk((g) === (w))
module testbench;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic clr = 1'b1;
  logic drv = 1'b0;
  logic drv2 = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] d;
  logic [63:0] st = 64'h0;
  wire [31:0] rdata_o;
  wire p1, p2, o1;
  wire [15:0] h1, r1;
  int err_total = 0;
  int samples_checked = 0;
  always #25 clock_i = ~clock_i;
  always @(posedge clock_i) st <= st + 64'h1;
  towsel_top #(.CW(32), .TW(64)) dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sys_time_i(st), .other_pin1_i(o1), .other_pin2_i(drv2), .gp_pin1_o(p1), .gp_pin2_o(p2));
  towsel_ext_model ext (.clock_i(clock_i), .clr_i(clr), .pin1_i(p1), .drive1_i(drv),
    .unit1_o(o1), .hi1_o(h1), .rise1_o(r1));
  task chk(input bit ok);
    samples_checked++;
    if (!ok) begin
      err_total++;
      $display("[ERR] %0t value differs", $time);
    end
  endtask
  task test_done;
    $display("compared %0d mismatched %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task wr(input logic [2:0] a, input logic [31:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [2:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    d = rdata_o;
  endtask
  // Write followed by a read with no gap, so the readback check sees both strobes.
  task wr_rd(input logic [2:0] a, input logic [31:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    d = rdata_o;
  endtask
  task run(input logic [31:0] c, w, cp, input int n);
    logic [63:0] t;
    t = st + 64'd40;
    clr <= 1'b1;
    wr(3'h5, 32'h0);
    wr(3'h0, c);
    wr(3'h1, w);
    wr(3'h2, cp);
    wr(3'h3, 32'h3);
    wr(3'h4, t[63:32]);
    wr(3'h4, t[31:0]);
    wr(3'h5, 32'h1);
    for (int i = 0; i < 60 && st < t; i++) @(posedge clock_i);
    `CHK(st >= t, 1'b1);
    clr <= 1'b0;
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  task t_regs;
    rd(3'h0);
    `CHK(d, 32'h0);
    wr_rd(3'h0, 32'hffffffff);
    `CHK(d, 32'hc071ffff);
    rd(3'h7);
    `CHK(d, 32'h0);
    $display("test registers done");
  endtask
  task t_reserved;
    run(32'h00700000, 32'h2, 32'h0, 30);
    `CHK(h1, 16'h0);
    $display("test reserved done");
  endtask
  task t_other;
    @(posedge clock_i);
    drv <= 1'b1;
    drv2 <= 1'b1;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    `CHK({p1, p2}, 2'b11);
    @(posedge clock_i);
    drv <= 1'b0;
    drv2 <= 1'b0;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    `CHK({p1, p2}, 2'b00);
    $display("test other units done");
  endtask
  task t_rise;
    run(32'h00110000, 32'h2, 32'h0, 30);
    `CHK({p2, h1}, {1'b1, 16'h0});
    $display("test rise done");
  endtask
  // The pin idles high, so the two samples before the edge reaches the pin count high.
  task t_fall;
    run(32'h0, 32'h2, 32'h0, 30);
    `CHK({p1, r1, h1}, {1'b0, 16'h0, 16'd2});
    $display("test fall done");
  endtask
  task t_low_pulse;
    run(32'h00200000, 32'h2, 32'h0, 30);
    `CHK({p1, 16'd30 - h1}, {1'b1, 16'd3});
    $display("test low pulse done");
  endtask
  task t_high_pulse;
    run(32'h00300000, 32'h2, 32'h0, 30);
    `CHK({p1, h1, r1}, {1'b0, 16'd3, 16'd1});
    $display("test high pulse done");
  endtask
  task t_low_period;
    run(32'h00400000, 32'h5, 32'h00030000, 60);
    `CHK(16'd60 - h1, 16'd9);
    $display("test low period done");
  endtask
  task t_high_period;
    run(32'h00500000, 32'h5, 32'h00030000, 60);
    `CHK({h1, r1}, {16'd9, 16'd3});
    $display("test high period done");
  endtask
  task t_endless_period;
    run(32'h00500000, 32'h5, 32'h0, 200);
    `CHK(r1 > 16'd30, 1'b1);
    $display("test endless period done");
  endtask
  task t_pattern;
    run(32'h00600000, 32'h2, 32'h0018ff00, 100);
    `CHK(h1, 16'd32);
    $display("test pattern done");
  endtask
  task t_endless_pattern;
    run(32'h00600000, 32'h2, 32'h0000ff00, 200);
    `CHK(h1 > 16'd64, 1'b1);
    $display("test endless pattern done");
  endtask
  task t_tail;
    run(32'hc0600001, 32'h2, 32'h0000ff00, 120);
    `CHK(h1, 16'd32);
    $display("test tail done");
  endtask
  task t_no_tail;
    run(32'h80600001, 32'h2, 32'h0000ff00, 300);
    `CHK(h1 > 16'd64, 1'b1);
    $display("test no tail done");
  endtask
  initial begin
    repeat (20) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_reserved();
    t_other();
    t_rise();
    t_fall();
    t_low_pulse();
    t_high_pulse();
    t_low_period();
    t_high_period();
    t_endless_period();
    t_pattern();
    t_endless_pattern();
    t_tail();
    t_no_tail();
    test_done();
  end
endmodule
`default_nettype wire
